// File: logic/srs_pkg.sv
// Shared constants and types for the receive status and vector block.
package srs_pkg;
	localparam int DW = 32;
	localparam int AW = 8;
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_VECRB = 8'h04;
	localparam logic [7:0] OFF_VECCTL = 8'h08;
	localparam logic [7:0] OFF_MODE = 8'h0c;
	localparam logic [7:0] OFF_CMD = 8'h10;
	localparam logic [7:0] OFF_PEND = 8'h14;
	localparam int ST_SENT = 0;
	localparam int ST_RES_LO = 1;
	localparam int ST_PAR = 4;
	localparam int ST_OVR = 5;
	localparam int ST_CRCFE = 6;
	localparam int ST_EOF = 7;
	localparam int MD_CAV = 0;
	localparam int MD_BUS = 1;
	localparam int MD_PARSPEC = 2;
	localparam int MD_PAREN = 3;
	localparam int MD_ODD = 4;
	localparam int MD_SYNC = 5;
	localparam int MD_SDLC = 6;
	localparam int MD_INTEN = 7;
	localparam int CMD_ERRRST = 0;
	localparam int FIFO_DEPTH = 3;
	localparam logic [2:0] CODE_NONE = 3'h7;
	localparam logic [7:0] VEC_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam int HALF_BIT_NS = 4340;
	localparam int CLK_NS = 10;
	localparam int HALF_BIT_CYC = (HALF_BIT_NS + CLK_NS - 1) / CLK_NS;
	typedef struct packed {
		logic [7:0] data;
		logic [2:0] residue;
		logic crcErr;
		logic eof;
	} srs_entry_s;
	typedef enum logic [1:0] {SRS_IDLE = 2'b00, SRS_HOLD = 2'b01} srs_rx_e;
endpackage : srs_pkg

// File: logic/srs_rx_fifo.sv
// Three-entry receive buffer holding each character with its own status.
`timescale 1ns/100ps
module srs_rx_fifo #(
	parameter int DEPTH = srs_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire srs_pkg::srs_entry_s inEntry,
	input wire logic pop,
	output srs_pkg::srs_entry_s head,
	output logic notEmpty,
	output logic overrun
);
	typedef struct packed {
		srs_pkg::srs_entry_s [DEPTH-1:0] mem;
		logic [1:0] count;
	} srs_fifo_s;
	srs_fifo_s r;
	srs_fifo_s next_r;
	always_comb begin
		next_r = r;
		if (pop && r.count != 2'h0) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_r.mem[i] = r.mem[i + 1];
			end
			next_r.count = r.count - 2'h1;
		end
		if (push) begin
			if (next_r.count == 2'(DEPTH)) begin
				next_r.mem[DEPTH - 1] = inEntry;
			end else begin
				next_r.mem[next_r.count] = inEntry;
				next_r.count = next_r.count + 2'h1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign head = r.mem[0];
	assign notEmpty = r.count != 2'h0;
	assign overrun = push && !(pop && r.count != 2'h0) && r.count == 2'(DEPTH);
endmodule : srs_rx_fifo

// File: logic/srs_status.sv
// Receive status flags, error latching and vector readback over APB.
`timescale 1ns/100ps
module srs_status #(
	parameter int HALF_BIT_CYC = srs_pkg::HALF_BIT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [srs_pkg::AW-1:0] paddr,
	input wire logic [srs_pkg::DW-1:0] pwdata,
	output logic [srs_pkg::DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic rxParityBit,
	input wire logic rxStopLow,
	input wire logic rxCrcMismatch,
	input wire logic rxClosingFlag,
	input wire logic rxFrameStart,
	input wire logic [2:0] rxResidue,
	input wire logic rxPop,
	input wire logic txEmptyB,
	input wire logic extStatB,
	input wire logic [1:0] chanAPend,
	input wire logic txEmptyA,
	input wire logic extStatA,
	output logic [7:0] rxHeadData,
	output logic rxHeadValid,
	output logic specialReq,
	output logic rxHold,
	output logic allSent
);
	typedef struct packed {
		logic [7:0] vecCtl;
		logic [7:0] mode;
		logic parErr;
		logic ovrErr;
		logic eofSticky;
		srs_pkg::srs_rx_e rxState;
		logic hold;
		logic [15:0] holdCnt;
		logic [srs_pkg::DW-1:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] headData;
		logic headValid;
		logic specialReq;
		logic pendA;
	} srs_state_s;
	srs_state_s r;
	srs_state_s next_r;
	srs_pkg::srs_entry_s inEntry;
	srs_pkg::srs_entry_s head;
	logic notEmpty;
	logic overrun;
	logic calcPar;
	logic parBad;
	logic framing;
	logic errReset;
	logic [7:0] statusByte;
	logic [7:0] vecRead;
	logic [7:0] pend;
	logic wrAcc;
	logic rdAcc;
	srs_vec_if vif ();
	srs_rx_fifo #(
		.DEPTH(srs_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.push(rxValid && r.rxState == srs_pkg::SRS_IDLE),
		.inEntry(inEntry),
		.pop(rxPop),
		.head(head),
		.notEmpty(notEmpty),
		.overrun(overrun)
	);
	srs_vec_enc u_enc (
		.vif(vif)
	);
	assign wrAcc = psel && penable && pwrite && !r.pready;
	assign rdAcc = psel && penable && !pwrite && !r.pready;
	assign errReset = wrAcc && paddr == srs_pkg::OFF_CMD && pwdata[srs_pkg::CMD_ERRRST];
	always_comb begin
		calcPar = ^rxData ^ r.mode[srs_pkg::MD_ODD];
		parBad = r.mode[srs_pkg::MD_PAREN] && (calcPar != rxParityBit);
		framing = !r.mode[srs_pkg::MD_SYNC] && rxStopLow;
		inEntry.data = rxData;
		inEntry.residue = r.mode[srs_pkg::MD_SDLC] ? rxResidue : 3'h0;
		inEntry.crcErr = r.mode[srs_pkg::MD_SYNC] ? rxCrcMismatch : framing;
		inEntry.eof = r.mode[srs_pkg::MD_SDLC] && rxClosingFlag;
	end
	always_comb begin
		statusByte = '0;
		statusByte[srs_pkg::ST_SENT] = !r.mode[srs_pkg::MD_SYNC] ? !notEmpty : 1'b1;
		statusByte[srs_pkg::ST_RES_LO +: 3] = notEmpty ? head.residue : 3'h0;
		statusByte[srs_pkg::ST_PAR] = r.parErr;
		statusByte[srs_pkg::ST_OVR] = r.ovrErr;
		statusByte[srs_pkg::ST_CRCFE] = notEmpty && head.crcErr;
		statusByte[srs_pkg::ST_EOF] = r.eofSticky;
	end
	// Channel A sources sit at the highest priority; with nothing pending the code is 7, the same code as chanAPend[1].
	always_comb begin
		pend = '0;
		pend[0] = chanAPend[1];
		pend[1] = chanAPend[0];
		pend[2] = extStatA;
		pend[3] = txEmptyA;
		pend[4] = r.specialReq;
		pend[5] = notEmpty && r.mode[srs_pkg::MD_INTEN];
		pend[6] = extStatB;
		pend[7] = txEmptyB;
	end
	assign vif.pending = pend;
	always_comb begin
		vecRead = r.vecCtl;
		if (r.mode[srs_pkg::MD_CAV]) begin
			if (r.mode[srs_pkg::MD_BUS]) begin
				vecRead[2:0] = vif.code;
			end else begin
				vecRead[4:2] = vif.code;
			end
		end
	end
	always_comb begin
		next_r = r;
		next_r.pready = psel && penable && !r.pready;
		next_r.pslverr = 1'b0;
		if (wrAcc) begin
			unique case (paddr)
				srs_pkg::OFF_VECCTL: next_r.vecCtl = pwdata[7:0];
				srs_pkg::OFF_MODE: next_r.mode = pwdata[7:0];
				srs_pkg::OFF_CMD: next_r.vecCtl = r.vecCtl;
				srs_pkg::OFF_STATUS, srs_pkg::OFF_VECRB, srs_pkg::OFF_PEND: next_r.pslverr = 1'b0;
				default: next_r.pslverr = 1'b1;
			endcase
		end
		if (rdAcc) begin
			next_r.prdata = '0;
			unique case (paddr)
				srs_pkg::OFF_STATUS: next_r.prdata[7:0] = statusByte;
				srs_pkg::OFF_VECRB: begin
					next_r.prdata[7:0] = vecRead;
					// pending bit valid after vector read
					next_r.pendA = |pend[3:0];
				end
				srs_pkg::OFF_VECCTL: next_r.prdata[7:0] = r.vecCtl;
				srs_pkg::OFF_MODE: next_r.prdata[7:0] = r.mode;
				srs_pkg::OFF_CMD: next_r.prdata = '0;
				srs_pkg::OFF_PEND: next_r.prdata[0] = r.pendA;
				default: next_r.pslverr = 1'b1;
			endcase
		end
		// sticky errors, set wins over clear
		if (errReset) begin
			next_r.parErr = 1'b0;
			next_r.ovrErr = 1'b0;
		end
		if (rxValid && r.rxState == srs_pkg::SRS_IDLE && parBad) begin
			next_r.parErr = 1'b1;
		end
		if (overrun) begin
			next_r.ovrErr = 1'b1;
		end
		if (errReset || (rxValid && rxFrameStart)) begin
			next_r.eofSticky = 1'b0;
		end
		if (rxValid && r.rxState == srs_pkg::SRS_IDLE && inEntry.eof) begin
			next_r.eofSticky = 1'b1;
		end
		unique case (r.rxState)
			srs_pkg::SRS_IDLE: begin
				if (rxValid && framing) begin
					next_r.rxState = srs_pkg::SRS_HOLD;
					next_r.holdCnt = 16'(HALF_BIT_CYC - 1);
				end
			end
			srs_pkg::SRS_HOLD: begin
				if (r.holdCnt == 16'h0) begin
					next_r.rxState = srs_pkg::SRS_IDLE;
				end else begin
					next_r.holdCnt = r.holdCnt - 16'h1;
				end
			end
			default: next_r.rxState = srs_pkg::SRS_IDLE;
		endcase
		// The hold pin gets a flop of its own so the output carries no decode.
		next_r.hold = next_r.rxState == srs_pkg::SRS_HOLD;
		next_r.specialReq = r.mode[srs_pkg::MD_INTEN] && ((r.parErr && r.mode[srs_pkg::MD_PARSPEC]) ||
			r.ovrErr || r.eofSticky || (notEmpty && head.crcErr && !r.mode[srs_pkg::MD_SYNC]));
		next_r.headData = head.data;
		next_r.headValid = notEmpty;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '0;
			r.vecCtl <= srs_pkg::VEC_RESET;
			r.mode <= srs_pkg::MODE_RESET;
			r.rxState <= srs_pkg::SRS_IDLE;
		end else begin
			r <= next_r;
		end
	end
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign rxHeadData = r.headData;
	assign rxHeadValid = r.headValid;
	assign specialReq = r.specialReq;
	assign rxHold = r.hold;
	assign allSent = r.headValid;
endmodule : srs_status

// File: logic/srs_vec_enc.sv
// Fixed priority encoder of the eight interrupt sources into a condition code.
`timescale 1ns/100ps
module srs_vec_enc (
	srs_vec_if.enc vif
);
	always_comb begin
		vif.code = srs_pkg::CODE_NONE;
		vif.anyPending = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (vif.pending[i] && !vif.anyPending) begin
				vif.code = 3'(7 - i);
				vif.anyPending = 1'b1;
			end
		end
	end
endmodule : srs_vec_enc

// File: logic/srs_vec_if.sv
// Interface carrying pending sources to the vector encoder.
`timescale 1ns/100ps
interface srs_vec_if;
	logic [7:0] pending;
	logic [2:0] code;
	logic anyPending;
	modport src(output pending, input code, anyPending);
	modport enc(input pending, output code, anyPending);
endinterface : srs_vec_if

// File: sim/srs_line_model.sv
// Far-end line station presenting completed characters.
`timescale 1ns/100ps
module srs_line_model (
	input wire logic clk,
	output logic rxValid = 1'b0,
	output logic [7:0] rxData = 8'h00,
	output logic rxParityBit = 1'b0,
	output logic rxStopLow = 1'b0,
	output logic rxCrcMismatch = 1'b0,
	output logic rxClosingFlag = 1'b0,
	output logic rxFrameStart = 1'b0,
	output logic [2:0] rxResidue = 3'h0
);
	// Qualifiers are inverted between characters so stale values are never trusted.
	task send(input logic [7:0] d, input logic p, input logic [3:0] f);
		@(posedge clk);
		rxValid <= 1'b1;
		rxData <= d;
		rxParityBit <= p;
		{rxFrameStart, rxClosingFlag, rxCrcMismatch, rxStopLow} <= f;
		rxResidue <= 3'h5;
		@(posedge clk);
		rxValid <= 1'b0;
		rxData <= ~d;
		rxParityBit <= ~p;
		{rxFrameStart, rxClosingFlag, rxCrcMismatch, rxStopLow} <= ~f;
		rxResidue <= 3'h2;
	endtask : send
endmodule : srs_line_model

// File: sim/srs_status_bench.sv
// Register-level bench for the receive status block.
`timescale 1ns/100ps
module srs_status_bench;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rxPop = 1'b0;
	logic txEmptyB = 1'b0, extStatB = 1'b0, txEmptyA = 1'b0, extStatA = 1'b0;
	logic [1:0] chanAPend = 2'h0;
	logic [7:0] paddr = 8'h00, rxData, rxHeadData;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, rerr, rxValid, rxParityBit, rxStopLow, rxCrcMismatch, rxClosingFlag, rxFrameStart;
	logic rxHeadValid, specialReq, rxHold, allSent;
	logic [2:0] rxResidue;
	int n_fail = 0, compares = 0;
	always #5 clk = ~clk;
	srs_status #(.HALF_BIT_CYC(4)) srs_status_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rxValid, .rxData, .rxParityBit, .rxStopLow, .rxCrcMismatch, .rxClosingFlag,
		.rxFrameStart, .rxResidue, .rxPop, .txEmptyB, .extStatB, .chanAPend, .txEmptyA, .extStatA, .rxHeadData,
		.rxHeadValid, .specialReq, .rxHold, .allSent);
	srs_line_model srs_line_model_i (.clk, .rxValid, .rxData, .rxParityBit, .rxStopLow, .rxCrcMismatch,
		.rxClosingFlag, .rxFrameStart, .rxResidue);
	task summarize;
		$display("Counts: %0d compares, %0d failures", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Pready is read just after the edge, so the value seen is the one that edge sampled.
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			summarize();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata & m, e);
	endtask : rd
	task pop;
		@(posedge clk);
		rxPop <= 1'b1;
		@(posedge clk);
		rxPop <= 1'b0;
	endtask : pop
	task src(input logic [7:0] s);
		@(posedge clk);
		txEmptyB <= s[0];
		extStatB <= s[1];
		txEmptyA <= s[4];
		extStatA <= s[5];
		chanAPend <= s[7:6];
	endtask : src
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h00, 32'hff, 32'h01);
		rd(8'h04, 32'hff, 32'h00);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(rerr), 32'h1);
		apb(1'b1, 8'h08, 32'ha5);
		rd(8'h04, 32'hff, 32'ha5);
		apb(1'b1, 8'h00, 32'hff);
		rd(8'h00, 32'hff, 32'h01);
		$display("Test registers done");
		apb(1'b1, 8'h0c, 32'h8c);
		srs_line_model_i.send(8'h03, 1'b1, 4'h0);
		srs_line_model_i.send(8'h01, 1'b1, 4'h0);
		rd(8'h00, 32'hfe, 32'h10);
		@(negedge clk);
		chk(32'(specialReq), 32'h1);
		chk(32'(rxHeadData), 32'h03);
		chk(32'(rxHeadValid), 32'h1);
		chk(32'(allSent), 32'h1);
		apb(1'b1, 8'h10, 32'h1);
		rd(8'h00, 32'hfe, 32'h00);
		pop();
		pop();
		apb(1'b1, 8'h0c, 32'h08);
		srs_line_model_i.send(8'h55, 1'b0, 4'h1);
		@(negedge clk);
		chk(32'(rxHold), 32'h1);
		srs_line_model_i.send(8'h33, 1'b0, 4'h0);
		repeat (10) @(negedge clk);
		chk(32'(rxHold), 32'h0);
		srs_line_model_i.send(8'h0f, 1'b0, 4'h0);
		rd(8'h00, 32'hfe, 32'h40);
		pop();
		rd(8'h00, 32'hfe, 32'h00);
		chk(32'(rxHeadData), 32'h0f);
		pop();
		for (int i = 1; i < 5; i++) begin
			srs_line_model_i.send(8'(i * 17), 1'b0, 4'h0);
		end
		rd(8'h00, 32'hfe, 32'h20);
		pop();
		pop();
		repeat (2) @(negedge clk);
		chk(32'(rxHeadData), 32'h44);
		apb(1'b1, 8'h10, 32'h1);
		pop();
		$display("Test async done");
		apb(1'b1, 8'h0c, 32'he0);
		srs_line_model_i.send(8'h42, 1'b0, 4'h2);
		repeat (2) @(negedge clk);
		chk(32'(specialReq), 32'h0);
		rd(8'h00, 32'hfe, 32'h4a);
		pop();
		srs_line_model_i.send(8'h7e, 1'b0, 4'h6);
		rd(8'h00, 32'hfe, 32'hca);
		apb(1'b1, 8'h10, 32'h1);
		rd(8'h00, 32'hfe, 32'h4a);
		pop();
		srs_line_model_i.send(8'h7e, 1'b0, 4'h4);
		srs_line_model_i.send(8'h01, 1'b0, 4'h8);
		pop();
		rd(8'h00, 32'hfe, 32'h0a);
		pop();
		$display("Test frame done");
		apb(1'b1, 8'h0c, 32'h81);
		apb(1'b1, 8'h08, 32'h00);
		rd(8'h04, 32'hff, 32'h1c);
		rd(8'h14, 32'h01, 32'h00);
		for (int i = 0; i < 8; i++) begin
			if (i != 2 && i != 3) begin
				src(8'h01 << i);
				rd(8'h04, 32'hff, 32'(i) << 2);
			end
		end
		rd(8'h14, 32'h01, 32'h01);
		src(8'h11);
		srs_line_model_i.send(8'h00, 1'b0, 4'h0);
		rd(8'h04, 32'hff, 32'h10);
		src(8'h00);
		rd(8'h04, 32'hff, 32'h08);
		apb(1'b1, 8'h0c, 32'h03);
		apb(1'b1, 8'h08, 32'ha0);
		src(8'h80);
		rd(8'h04, 32'hff, 32'ha7);
		$display("Test vector done");
		summarize();
	end
endmodule : srs_status_bench

// File: sim/srs_status_props.sv
// Port checks for the receive status block.
`timescale 1ns/100ps
module srs_status_props #(
	parameter int HALF_BIT_CYC = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxValid,
	input wire logic rxPop,
	input wire logic rxHold,
	input wire logic rxHeadValid
);
	int holdCnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_push;
		rxValid && !rxHold && !rxPop ##1 !rxPop;
	endsequence
	// The count bounds the wait so a stuck hold is seen.
	always_ff @(posedge clk) begin
		holdCnt <= (!rst_n || !rxHold) ? 0 : holdCnt + 1;
	end
	chk_ready_one_wait: assert property (s_access |=> pready) else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	chk_ready_idle: assert property (!(psel && penable) |=> !pready) else $error("pready unasked");
	chk_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	chk_unmapped_err: assert property ((s_access and (paddr > 8'h14)) |=> pslverr) else $error("no pslverr");
	chk_mapped_ok: assert property ((s_access and (paddr <= 8'h14 && paddr[1:0] == 2'h0)) |=> !pslverr)
		else $error("false pslverr");
	chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data");
	chk_push_head: assert property (s_push |-> ##[0:1] rxHeadValid) else $error("char lost");
	chk_hold_len: assert property (holdCnt <= HALF_BIT_CYC) else $error("hold too long");
endmodule : srs_status_props
bind srs_status srs_status_props #(.HALF_BIT_CYC(HALF_BIT_CYC)) srs_status_props_i (.clk, .rst_n, .psel,
	.penable, .paddr, .prdata, .pready, .pslverr, .rxValid, .rxPop, .rxHold, .rxHeadValid);
